// File: core/ust_pkg.sv
package ust_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_TIME_NS = 1000;
  localparam logic [7:0] BIT_CYCLES = 8'(BIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] HALF_BIT_CYCLES = 8'(BIT_TIME_NS / CLK_PERIOD_NS / 2);
  localparam logic [3:0] LINE_LOW_BITS = 4'hB;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_DATA = 4'h4;
  localparam logic [3:0] ADR_FLAGS = 4'h8;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // serial_status_control fields
  localparam int unsigned F_DBUF = 7;
  localparam int unsigned F_LATE = 6;
  localparam int unsigned F_SPLIT = 5;
  localparam int unsigned F_COUNT = 4;
  localparam int unsigned F_FRAME = 3;
  localparam int unsigned F_LOW = 2;
  localparam int unsigned F_OVER = 1;
  localparam int unsigned F_STATUS_IRQ_ENABLE = 0;
  // serial_flags fields
  localparam int unsigned F_TXI = 0;
  localparam int unsigned F_RXF = 1;
  localparam int unsigned F_TXBUSY = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ust_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ust_wb_rsp_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } ust_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } ust_rx_state_t;

endpackage

// File: core/ust_sync.sv
`timescale 1ns/1ps
module ust_sync
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ust_sync_st_t;

  ust_sync_st_t s;
  ust_sync_st_t next_s;

  // Three stages; output follows once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  // Line idles high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, q: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;

endmodule

// File: core/ust_buf.sv
`timescale 1ns/1ps
module ust_buf
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd;
    logic [1:0] count;
  } ust_buf_st_t;

  ust_buf_st_t s;
  ust_buf_st_t next_s;
  logic push;
  logic pop;

  // Two entries, honest full and empty
  assign in_ready = (s.count != 2'h2);
  assign out_valid = (s.count != 2'h0);
  assign out_data = s.mem[s.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Write at rd+count, read at rd
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.rd ^ s.count[0]] = in_data;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    next_s.count = s.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// File: core/ust_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Count select acts only with double buffering; software keeps it zero otherwise.
// - Count select set: one interrupt per character plus one after the last.
// - That final interrupt comes at stop bit start (late=0) or end (late=1).
// - Count select clear: exactly one transmit interrupt per character written.
// - Double buffered: a write into an empty transmitter interrupts at once, whatever late select says.
// - Other double buffered characters interrupt at the stop position chosen by late select; single buffered ones at stop end.
// - Overrun sets when a frame's last bit arrives with receive-full still set.
// - Eleven consecutive low bit samples set the line-low flag until cleared.
// - Double buffer off or on: the two-entry buffer takes writes while shifting; off loads the next character only from idle.
// - Double buffered with more data, late select picks stop start or end for load and interrupt.
module ust_top
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire ust_wb_req_t wb_req,
  output ust_wb_rsp_t wb_rsp,
  input wire logic rxd,
  output logic txd,
  output logic uart_irq,
  output logic tx_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic dbuf;
    logic late;
    logic split;
    logic count_sel;
    logic status_irq_enable;
    logic frame_err;
    logic line_low;
    logic overrun;
    logic txi;
    logic rxf;
    logic [7:0] rx_data;
    ust_tx_state_t tx_state;
    logic [7:0] tx_cnt;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic txd;
    logic pend_valid;
    logic [7:0] pend_data;
    ust_rx_state_t rx_state;
    logic [7:0] rx_cnt;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic [3:0] low_cnt;
  } ust_top_st_t;

  ust_top_st_t s;
  ust_top_st_t next_s;

  logic rxd_q;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;

  // Byte lane 0 write strobe for a given register
  function automatic logic wr_hit(input ust_wb_req_t r, input logic [3:0] adr);
    wr_hit = r.cyc && r.stb && r.we && r.sel[0] && (r.adr == adr);
  endfunction

  // Bit timer tick: counter reached its end
  function automatic logic bit_tick(input logic [7:0] cnt);
    bit_tick = (cnt == 8'h01);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  // Receive pin comes from outside the clock domain
  ust_sync ust_sync_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(rxd),
    .dout(rxd_q)
  );

  // Transmit data buffer, full stalls the bus answer
  ust_buf ust_buf_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(wb_req.dat[7:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic req;
    logic tx_event;
    logic clr_txi;
    logic clr_rxf;
    logic clr_fe;
    logic clr_br;
    logic clr_oe;
    logic cnt_eff;
    logic rx_sample;
    logic set_fe;
    logic set_br;
    logic set_oe;
    logic set_rxf;
    next_s = s;
    req = wb_req.cyc && wb_req.stb && !s.ack;
    tx_event = 1'b0;
    clr_txi = 1'b0;
    clr_rxf = 1'b0;
    clr_fe = 1'b0;
    clr_br = 1'b0;
    clr_oe = 1'b0;
    cnt_eff = s.count_sel && s.dbuf;
    rx_sample = 1'b0;
    set_fe = 1'b0;
    set_br = 1'b0;
    set_oe = 1'b0;
    set_rxf = 1'b0;
    buf_out_ready = 1'b0;
    buf_in_valid = req && wr_hit(wb_req, ADR_DATA);

    // Bus slave: ack one cycle after request, data write waits for room
    next_s.ack = 1'b0;
    if (req && !(buf_in_valid && !buf_in_ready)) begin
      next_s.ack = 1'b1;
      next_s.rdat = 32'h0000_0000;
      case (wb_req.adr)
        ADR_STATUS: begin
          next_s.rdat[F_DBUF] = s.dbuf;
          next_s.rdat[F_LATE] = s.late;
          next_s.rdat[F_SPLIT] = s.split;
          next_s.rdat[F_COUNT] = s.count_sel;
          next_s.rdat[F_FRAME] = s.frame_err;
          next_s.rdat[F_LOW] = s.line_low;
          next_s.rdat[F_OVER] = s.overrun;
          next_s.rdat[F_STATUS_IRQ_ENABLE] = s.status_irq_enable;
        end
        ADR_DATA: begin
          next_s.rdat[7:0] = s.rx_data;
        end
        ADR_FLAGS: begin
          next_s.rdat[F_TXI] = s.txi;
          next_s.rdat[F_RXF] = s.rxf;
          next_s.rdat[F_TXBUSY] = (s.tx_state != TX_IDLE);
        end
        default: begin
          next_s.rdat = 32'h0000_0000;
        end
      endcase
    end

    // Software writes: control bits store, flags clear on zero
    if (req && wr_hit(wb_req, ADR_STATUS)) begin
      next_s.dbuf = wb_req.dat[F_DBUF];
      next_s.late = wb_req.dat[F_LATE];
      next_s.split = wb_req.dat[F_SPLIT];
      next_s.count_sel = wb_req.dat[F_COUNT];
      next_s.status_irq_enable = wb_req.dat[F_STATUS_IRQ_ENABLE];
      clr_fe = !wb_req.dat[F_FRAME];
      clr_br = !wb_req.dat[F_LOW];
      clr_oe = !wb_req.dat[F_OVER];
    end
    if (req && wr_hit(wb_req, ADR_FLAGS)) begin
      clr_txi = !wb_req.dat[F_TXI];
      clr_rxf = !wb_req.dat[F_RXF];
    end

    // Transmitter bit timer
    if (s.tx_state != TX_IDLE) begin
      next_s.tx_cnt = bit_tick(s.tx_cnt) ? BIT_CYCLES : s.tx_cnt - 8'h01;
    end

    // Transmitter frame sequence
    case (s.tx_state)
      TX_IDLE: begin
        next_s.txd = 1'b1;
        if (buf_out_valid) begin
          buf_out_ready = 1'b1;
          next_s.tx_shift = buf_out_data;
          next_s.tx_cnt = BIT_CYCLES;
          next_s.txd = 1'b0;
          next_s.tx_state = TX_START;
          tx_event = s.dbuf;
        end
      end
      TX_START: begin
        if (bit_tick(s.tx_cnt)) begin
          next_s.txd = s.tx_shift[0];
          next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
          next_s.tx_idx = 3'h0;
          next_s.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bit_tick(s.tx_cnt)) begin
          if (s.tx_idx == LAST_DATA_BIT) begin
            next_s.txd = 1'b1;
            next_s.tx_state = TX_STOP;
            // Stop bit start: early load point
            if (s.dbuf && !s.late) begin
              if (buf_out_valid) begin
                buf_out_ready = 1'b1;
                next_s.pend_valid = 1'b1;
                next_s.pend_data = buf_out_data;
                tx_event = 1'b1;
              end else begin
                tx_event = cnt_eff;
              end
            end
          end else begin
            next_s.txd = s.tx_shift[0];
            next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
            next_s.tx_idx = s.tx_idx + 3'h1;
          end
        end
      end
      TX_STOP: begin
        if (bit_tick(s.tx_cnt)) begin
          next_s.tx_state = TX_IDLE;
          if (!s.dbuf) begin
            tx_event = 1'b1;
          end else if (s.pend_valid) begin
            next_s.pend_valid = 1'b0;
            next_s.tx_shift = s.pend_data;
            next_s.txd = 1'b0;
            next_s.tx_state = TX_START;
          end else if (s.late) begin
            // Stop bit end: late load point
            if (buf_out_valid) begin
              buf_out_ready = 1'b1;
              next_s.tx_shift = buf_out_data;
              next_s.txd = 1'b0;
              next_s.tx_state = TX_START;
              tx_event = 1'b1;
            end else begin
              tx_event = cnt_eff;
            end
          end
        end
      end
      default: begin
        next_s.tx_state = TX_IDLE;
        next_s.txd = 1'b1;
      end
    endcase

    // Receiver bit timer
    if (s.rx_state != RX_IDLE) begin
      next_s.rx_cnt = bit_tick(s.rx_cnt) ? BIT_CYCLES : s.rx_cnt - 8'h01;
      rx_sample = bit_tick(s.rx_cnt);
    end

    // Receiver frame sequence, sampled mid bit
    case (s.rx_state)
      RX_IDLE: begin
        if (!rxd_q) begin
          next_s.rx_cnt = HALF_BIT_CYCLES;
          next_s.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_sample) begin
          next_s.rx_idx = 3'h0;
          next_s.rx_state = rxd_q ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_sample) begin
          next_s.rx_shift = {rxd_q, s.rx_shift[7:1]};
          next_s.rx_idx = s.rx_idx + 3'h1;
          if (s.rx_idx == LAST_DATA_BIT) begin
            next_s.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_sample) begin
          next_s.rx_state = RX_IDLE;
          set_fe = !rxd_q;
          if (s.rxf) begin
            set_oe = 1'b1;
          end else begin
            set_rxf = 1'b1;
            next_s.rx_data = s.rx_shift;
          end
        end
      end
      default: begin
        next_s.rx_state = RX_IDLE;
      end
    endcase

    // Consecutive low bit samples across frames
    if (rx_sample) begin
      if (rxd_q) begin
        next_s.low_cnt = 4'h0;
      end else if (s.low_cnt != LINE_LOW_BITS) begin
        next_s.low_cnt = s.low_cnt + 4'h1;
        set_br = (s.low_cnt + 4'h1 == LINE_LOW_BITS);
      end
    end

    // Sticky flags: a set in the clearing cycle wins
    next_s.txi = tx_event || (s.txi && !clr_txi);
    next_s.rxf = set_rxf || (s.rxf && !clr_rxf);
    next_s.frame_err = set_fe || (s.frame_err && !clr_fe);
    next_s.line_low = set_br || (s.line_low && !clr_br);
    next_s.overrun = set_oe || (s.overrun && !clr_oe);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.dbuf <= STATUS_RESET[F_DBUF];
      s.late <= STATUS_RESET[F_LATE];
      s.split <= STATUS_RESET[F_SPLIT];
      s.count_sel <= STATUS_RESET[F_COUNT];
      s.status_irq_enable <= STATUS_RESET[F_STATUS_IRQ_ENABLE];
      s.tx_state <= TX_IDLE;
      s.rx_state <= RX_IDLE;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic err_irq;
  assign err_irq = s.status_irq_enable && (s.frame_err || s.line_low || s.overrun);

  // Combined or split interrupt steering
  assign uart_irq = s.split ? (s.rxf || err_irq) : (s.txi || s.rxf || err_irq);
  assign tx_irq = s.split && s.txi;
  assign txd = s.txd;
  assign wb_rsp.ack = s.ack;
  assign wb_rsp.dat = s.rdat;

endmodule

// File: tb/ust_checker.sv
`timescale 1ns/1ps
module ust_checker
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire ust_wb_req_t wb_req,
  input wire ust_wb_rsp_t wb_rsp,
  input wire logic rxd,
  input wire logic txd,
  input wire logic uart_irq,
  input wire logic tx_irq
);
  logic split_q;
  logic [15:0] low_cnt;
  logic [7:0] hi_cnt;
  logic st_wr;

  // Status write taken at this edge
  assign st_wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_rsp.ack &&
                 wb_req.adr == ADR_STATUS && wb_req.sel[0];

  // Shadow of the split bit and run lengths of the serial output
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      split_q <= 1'b0;
      low_cnt <= 16'h0000;
      hi_cnt <= 8'hFF;
    end else begin
      if (st_wr) begin
        split_q <= wb_req.dat[F_SPLIT];
      end
      low_cnt <= txd ? 16'h0000 : low_cnt + 16'h0001;
      hi_cnt <= !txd ? 8'h00 : ((hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_ack_pulse;
    wb_rsp.ack |=> !wb_rsp.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_time;
    $rose(wb_req.stb) && wb_req.adr != ADR_DATA |-> ##1 wb_rsp.ack;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("register ack late");
  property p_unmapped;
    wb_rsp.ack && !wb_req.we && wb_req.adr != ADR_STATUS && wb_req.adr != ADR_DATA &&
      wb_req.adr != ADR_FLAGS |-> wb_rsp.dat == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tx_split;
    tx_irq |-> split_q;
  endproperty
  a_tx_split: assert property (p_tx_split) else $error("tx irq while combined");
  property p_irq_hold;
    $fell(uart_irq) |-> wb_rsp.ack && wb_req.we;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
  property p_tx_hold;
    $fell(tx_irq) |-> wb_rsp.ack && wb_req.we;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx irq dropped by itself");
  property p_bit_len;
    $rose(txd) |-> (low_cnt % 16'(BIT_CYCLES)) == 16'h0000;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
  property p_stop_gap;
    $fell(txd) |-> hi_cnt >= BIT_CYCLES;
  endproperty
  a_stop_gap: assert property (p_stop_gap) else $error("stop bit too short");
endmodule

bind ust_top ust_checker ust_checker_i (.core_clk(core_clk), .rstn(rstn), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .rxd(rxd), .txd(txd), .uart_irq(uart_irq), .tx_irq(tx_irq));

// File: tb/ust_remote.sv
`timescale 1ns/1ps
module ust_remote
  import ust_pkg::*;
(
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] q[$];
  logic [7:0] b;

  initial rxd = 1'b1;

  // Sends nb bits LSB first, one bit time each, then idles high
  task automatic send(input logic [13:0] f, input int nb);
    @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (int'(BIT_CYCLES)) @(posedge core_clk);
    end
    rxd <= 1'b1;
  endtask

  // Receiver: mid-bit sampling, byte queued at mid stop bit
  initial forever begin
    @(negedge txd);
    repeat (int'(HALF_BIT_CYCLES)) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (int'(BIT_CYCLES)) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (int'(BIT_CYCLES)) @(posedge core_clk);
    q.push_back(b);
  end
endmodule

// File: tb/tb_ust_top.sv
`timescale 1ns/1ps
module tb_ust_top;
  import ust_pkg::*;
  logic core_clk;
  logic rstn = 1'b0;
  ust_wb_req_t wb_req = '0;
  ust_wb_rsp_t wb_rsp;
  logic rxd;
  logic txd;
  logic uart_irq;
  logic tx_irq;
  logic seen;
  logic [31:0] rdat;
  int fail_count = 0;
  int tests_run = 0;
  int cyc_n = 0;
  int n0;

  ust_top ust_top_i (.core_clk(core_clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .rxd(rxd), .txd(txd), .uart_irq(uart_irq), .tx_irq(tx_irq));
  ust_remote ust_remote_i (.core_clk(core_clk), .txd(txd), .rxd(rxd));

  // ********
  // Clock and timeout
  // ********
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: expected %h got %h", $time, e, g);
    end
  endtask
  // Single Wishbone cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h000000, d}};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 3000);
    rdat = wb_rsp.dat; // Taken at the ack edge
    wb_req <= '0;
    if (n >= 3000) chk(8'h01, 8'h00);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(e, rdat[7:0]);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    while (tx_irq !== 1'b1 && n < 1500) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'h01, {7'h00, tx_irq});
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ADR_STATUS, STATUS_RESET);
    rd(4'hC, 8'h00);
    wb(1'b1, ADR_STATUS, 8'hFF);
    rd(ADR_STATUS, 8'hF1);
    // Two characters, early then late placement
    for (int l = 0; l < 2; l++) begin
      wb(1'b1, ADR_STATUS, {1'b1, l[0], 6'h30});
      wb(1'b1, ADR_FLAGS, 8'h00);
      n0 = ust_remote_i.q.size();
      wb(1'b1, ADR_DATA, 8'hA5);
      @(negedge core_clk);
      chk(8'h01, {7'h00, tx_irq});
      wb(1'b1, ADR_DATA, 8'h5A);
      wb(1'b1, ADR_FLAGS, 8'h00);
      wait_tx();
      chk(8'(n0 + l), 8'(ust_remote_i.q.size()));
      wb(1'b1, ADR_FLAGS, 8'h00);
      wait_tx();
      chk(8'(n0 + 1 + l), 8'(ust_remote_i.q.size()));
      repeat (150) @(negedge core_clk);
      chk(8'hA5, ust_remote_i.q[n0]);
      chk(8'h5A, ust_remote_i.q[n0 + 1]);
    end
    // No final interrupt with count select clear
    wb(1'b1, ADR_STATUS, 8'hA0);
    wb(1'b1, ADR_FLAGS, 8'h00);
    wb(1'b1, ADR_DATA, 8'h33);
    wb(1'b1, ADR_FLAGS, 8'h00);
    seen = 1'b0;
    repeat (1300) begin
      @(negedge core_clk);
      seen |= tx_irq;
    end
    chk(8'h00, {7'h00, seen});
    chk(8'h33, ust_remote_i.q[$]);
    // Single buffered: interrupt only after the stop bit
    wb(1'b1, ADR_STATUS, 8'h20);
    n0 = ust_remote_i.q.size();
    wb(1'b1, ADR_DATA, 8'h66);
    @(negedge core_clk);
    chk(8'h00, {7'h00, tx_irq});
    wait_tx();
    chk(8'(n0 + 1), 8'(ust_remote_i.q.size()));
    // Fill the buffer until writes stall
    wb(1'b1, ADR_STATUS, 8'hE0);
    n0 = ust_remote_i.q.size();
    for (int k = 0; k < 5; k++) wb(1'b1, ADR_DATA, 8'h10 + 8'(k));
    repeat (6000) @(negedge core_clk);
    for (int k = 0; k < 5; k++) chk(8'h10 + 8'(k), ust_remote_i.q[n0 + k]);
    // Combined interrupt
    wb(1'b1, ADR_STATUS, 8'h80);
    wb(1'b1, ADR_FLAGS, 8'h00);
    wb(1'b1, ADR_DATA, 8'h11);
    @(negedge core_clk);
    chk(8'h01, {6'h00, tx_irq, uart_irq});
    repeat (1100) @(posedge core_clk);
    // Receive flags and error gating
    wb(1'b1, ADR_STATUS, 8'h21);
    wb(1'b1, ADR_FLAGS, 8'h00);
    ust_remote_i.send({5'h01, 8'h3C, 1'b0}, 10);
    rd(ADR_FLAGS, 8'h02);
    chk(8'h01, {7'h00, uart_irq});
    ust_remote_i.send({5'h01, 8'h5A, 1'b0}, 10);
    rd(ADR_STATUS, 8'h23);
    rd(ADR_DATA, 8'h3C);
    ust_remote_i.send({5'h00, 8'h81, 1'b0}, 10);
    rd(ADR_STATUS, 8'h2B);
    ust_remote_i.send(14'h0000, 14);
    repeat (1200) @(posedge core_clk);
    rd(ADR_STATUS, 8'h2F);
    wb(1'b1, ADR_FLAGS, 8'h00);
    wb(1'b1, ADR_STATUS, 8'h2E);
    @(negedge core_clk);
    chk(8'h00, {7'h00, uart_irq});
    wb(1'b1, ADR_STATUS, 8'h2F);
    @(negedge core_clk);
    chk(8'h01, {7'h00, uart_irq});
    wb(1'b1, ADR_STATUS, 8'h21);
    rd(ADR_STATUS, 8'h21);
    stop_test();
  end
endmodule
